// File: rtl/timing_pattern_output.sv
// Timing pattern output unit: register file, trigger selection and port data
//
// What this block does
// - Up to twelve pattern output bits, each enabled for pattern output separately.
// - Three four-bit groups on pins 0-3, 4-7, 8-11, running independently.
// - Each group's trigger is one of four timer compare-match channels.
// - Non-overlap mode inserts a margin between successive output changes.
// - Port direction registers are write-only, bit per pin, reset to zero.
// - Port A data bits enabled for pattern output ignore CPU writes.
// - Port B data bits 3-0 enabled for pattern output ignore CPU writes; bits 7-4 always take them.
// - Selected compare-match copies group 0/1 next data into port A data.
// - Next-data registers clear on reset and on hardware standby entry.
// - Next-data registers keep their contents through software standby.
// - Shared trigger for groups 0/1: one byte at FFA5, high nibble group 1.
// - Shared trigger for groups 0/1: FFA7 reads all ones, ignores writes.
// - Separate triggers: group 0 data at FFA7, group 1 at FFA5.
// - Shared trigger for groups 2/3: next data byte at FFA4.
// - Separate triggers for groups 2/3: group 2 data at FFA6.
// - Group 3 has no pins; its next data is storage only.
// - Mode register resets to F0, control register to FF; both read/write.
// - Disabled bits are not copied on a trigger; output stays unchanged.
// - Separate triggers 0/1: FFA5 low nibble and FFA7 high nibble read one.
`timescale 1ns/10ps
module timing_pattern_output
  import pattern_output_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               hw_standby,
  input  wire logic [TRIG_CH-1:0] cmp_match,
  input  wire cpu_req_t           req,
  output logic [7:0]              rdata,
  output logic [7:0]              pa_out,
  output logic [7:0]              pa_oe,
  output logic [7:0]              pb_out,
  output logic [7:0]              pb_oe
);

  // ********************************
  // Helpers
  // ********************************
  // Writable mask of a next-data address, primary or secondary
  function automatic logic [7:0] nd_mask(input logic same, input logic sec);
    logic [7:0] m;
    m = same ? (sec ? ZERO_RST : RESERVED_READ) : (sec ? LOWER_NIBBLE : UPPER_NIBBLE);
    return m;
  endfunction : nd_mask

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] m);
    logic [7:0] r;
    r = (old & ~m) | (nw & m);
    return r;
  endfunction : merge

  // ********************************
  // State
  // ********************************
  logic [7:0]       mode_r;
  logic [7:0]       ctrl_r;
  logic [7:0]       en_hi_r;
  logic [7:0]       en_lo_r;
  logic [7:0]       nd_hi_r;
  logic [7:0]       nd_lo_r;
  logic [7:0]       pa_dir_r;
  logic [7:0]       pb_dir_r;
  logic [7:0]       pa_data_r;
  logic [7:0]       pb_data_r;
  logic [7:0]       rdata_r;
  logic             stby_s1_r;
  logic             stby_s2_r;

  logic [7:0]       mode_nxt;
  logic [7:0]       ctrl_nxt;
  logic [7:0]       en_hi_nxt;
  logic [7:0]       en_lo_nxt;
  logic [7:0]       nd_hi_nxt;
  logic [7:0]       nd_lo_nxt;
  logic [7:0]       pa_dir_nxt;
  logic [7:0]       pb_dir_nxt;
  logic [7:0]       pa_data_nxt;
  logic [7:0]       pb_data_nxt;
  logic [7:0]       rdata_nxt;

  // ********************************
  // Decode
  // ********************************
  logic             wipe;
  logic             wr_mode;
  logic             wr_ctrl;
  logic             wr_en_hi;
  logic             wr_en_lo;
  logic             wr_hi_pri;
  logic             wr_lo_pri;
  logic             wr_hi_sec;
  logic             wr_lo_sec;
  logic             wr_pa_dir;
  logic             wr_pb_dir;
  logic             wr_pa_data;
  logic             wr_pb_data;
  logic             same_lo;
  logic             same_hi;
  logic [7:0]       m_lo_pri;
  logic [7:0]       m_lo_sec;
  logic [7:0]       m_hi_pri;
  logic [7:0]       m_hi_sec;
  logic [7:0]       pa_cpu;
  logic [7:0]       pb_cpu;
  logic [7:0]       pb_lock;
  logic [15:0]      en_all;
  logic [15:0]      nd_all;
  logic [PIN_GROUPS-1:0] gtrig;
  group_upd_t       upd [PIN_GROUPS];

  // Hardware standby acts like reset once synchronised
  assign wipe       = !nrst || stby_s2_r;

  assign wr_mode    = req.wr && (req.addr == PATTERN_MODE_ADDR);
  assign wr_ctrl    = req.wr && (req.addr == TRIGGER_CTRL_ADDR);
  assign wr_en_hi   = req.wr && (req.addr == ENABLE_HI_ADDR);
  assign wr_en_lo   = req.wr && (req.addr == ENABLE_LO_ADDR);
  assign wr_hi_pri  = req.wr && (req.addr == NEXT_HI_PRI_ADDR);
  assign wr_lo_pri  = req.wr && (req.addr == NEXT_LO_PRI_ADDR);
  assign wr_hi_sec  = req.wr && (req.addr == NEXT_HI_SEC_ADDR);
  assign wr_lo_sec  = req.wr && (req.addr == NEXT_LO_SEC_ADDR);
  assign wr_pa_dir  = req.wr && (req.addr == PORT_A_DIR_ADDR);
  assign wr_pb_dir  = req.wr && (req.addr == PORT_B_DIR_ADDR);
  assign wr_pa_data = req.wr && (req.addr == PORT_A_DATA_ADDR);
  assign wr_pb_data = req.wr && (req.addr == PORT_B_DATA_ADDR);

  // ********************************
  // Trigger selection
  // ********************************
  // Two select bits per group; group 3 uses the top field
  assign same_lo = (ctrl_r[1:0] == ctrl_r[3:2]);
  assign same_hi = (ctrl_r[5:4] == ctrl_r[7:6]);

  generate
    for (genvar g = 0; g < PIN_GROUPS; g++) begin : g_grp
      // Timer pulses share this clock, so no synchroniser
      assign gtrig[g] = cmp_match[ctrl_r[SEL_W*g +: SEL_W]];
      group_stage u_stage (
        .clk  (clk),
        .wipe (wipe),
        .trig (gtrig[g]),
        .nov  (mode_r[g]),
        .en   (en_all[GROUP_W*g +: GROUP_W]),
        .nd   (nd_all[GROUP_W*g +: GROUP_W]),
        .upd  (upd[g])
      );
    end
  endgenerate

  assign en_all = {en_hi_r, en_lo_r};
  assign nd_all = {nd_hi_r, nd_lo_r};

  // ********************************
  // Next-data addressing
  // ********************************
  assign m_lo_pri  = nd_mask(same_lo, 1'b0);
  assign m_lo_sec  = nd_mask(same_lo, 1'b1);
  assign m_hi_pri  = nd_mask(same_hi, 1'b0);
  assign m_hi_sec  = nd_mask(same_hi, 1'b1);

  // Reserved parts of each address drop the write
  assign nd_lo_nxt = wr_lo_pri ? merge(nd_lo_r, req.wdata, m_lo_pri) :
                     (wr_lo_sec ? merge(nd_lo_r, req.wdata, m_lo_sec) : nd_lo_r);
  assign nd_hi_nxt = wr_hi_pri ? merge(nd_hi_r, req.wdata, m_hi_pri) :
                     (wr_hi_sec ? merge(nd_hi_r, req.wdata, m_hi_sec) : nd_hi_r);

  // ********************************
  // Plain registers
  // ********************************
  assign mode_nxt   = wr_mode   ? req.wdata : mode_r;
  assign ctrl_nxt   = wr_ctrl   ? req.wdata : ctrl_r;
  assign en_hi_nxt  = wr_en_hi  ? req.wdata : en_hi_r;
  assign en_lo_nxt  = wr_en_lo  ? req.wdata : en_lo_r;
  assign pa_dir_nxt = wr_pa_dir ? req.wdata : pa_dir_r;
  assign pb_dir_nxt = wr_pb_dir ? req.wdata : pb_dir_r;

  // ********************************
  // Port data
  // ********************************
  // Enabled bits belong to the pattern logic, not the CPU
  assign pa_cpu  = wr_pa_data ? merge(pa_data_r, req.wdata, ~en_lo_r) : pa_data_r;
  // Group 3 has no pins, so port B bits 7-4 stay ordinary
  assign pb_lock = {4'h0, en_hi_r[3:0]};
  assign pb_cpu  = wr_pb_data ? merge(pb_data_r, req.wdata, ~pb_lock) : pb_data_r;

  // In direct mode the whole group lands on the edge that sees the trigger
  assign pa_data_nxt = (pa_cpu & ~{upd[1].clr, upd[0].clr})
                     | {upd[1].set, upd[0].set};
  assign pb_data_nxt = (pb_cpu & ~{4'h0, upd[2].clr})
                     | {4'h0, upd[2].set};

  // ********************************
  // Read path
  // ********************************
  // Direction registers are write-only and read back zero
  assign rdata_nxt =
    !req.rd                            ? rdata_r :
    (req.addr == PATTERN_MODE_ADDR)    ? mode_r :
    (req.addr == TRIGGER_CTRL_ADDR)    ? ctrl_r :
    (req.addr == ENABLE_HI_ADDR)       ? en_hi_r :
    (req.addr == ENABLE_LO_ADDR)       ? en_lo_r :
    (req.addr == NEXT_LO_PRI_ADDR)     ? ((nd_lo_r & m_lo_pri) | ~m_lo_pri) :
    (req.addr == NEXT_LO_SEC_ADDR)     ? ((nd_lo_r & m_lo_sec) | ~m_lo_sec) :
    (req.addr == NEXT_HI_PRI_ADDR)     ? ((nd_hi_r & m_hi_pri) | ~m_hi_pri) :
    (req.addr == NEXT_HI_SEC_ADDR)     ? ((nd_hi_r & m_hi_sec) | ~m_hi_sec) :
    (req.addr == PORT_A_DATA_ADDR)     ? pa_data_r :
    (req.addr == PORT_B_DATA_ADDR)     ? pb_data_r :
    (req.addr == PORT_A_DIR_ADDR)      ? WRITE_ONLY_READ :
    (req.addr == PORT_B_DIR_ADDR)      ? WRITE_ONLY_READ :
                                         UNMAPPED_READ;

  // ********************************
  // Flip-flops
  // ********************************
  always_ff @(posedge clk) begin
    stby_s1_r <= hw_standby;
    stby_s2_r <= stby_s1_r;
  end

  always_ff @(posedge clk) begin
    if (wipe) begin
      mode_r   <= PATTERN_MODE_RST;
      ctrl_r   <= TRIGGER_CTRL_RST;
      en_hi_r  <= ZERO_RST;
      en_lo_r  <= ZERO_RST;
      nd_hi_r  <= ZERO_RST;
      nd_lo_r  <= ZERO_RST;
      pa_dir_r <= ZERO_RST;
      pb_dir_r <= ZERO_RST;
    end else begin
      mode_r   <= mode_nxt;
      ctrl_r   <= ctrl_nxt;
      en_hi_r  <= en_hi_nxt;
      en_lo_r  <= en_lo_nxt;
      // Only reset and hardware standby clear these; no other standby does
      nd_hi_r  <= nd_hi_nxt;
      nd_lo_r  <= nd_lo_nxt;
      pa_dir_r <= pa_dir_nxt;
      pb_dir_r <= pb_dir_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (wipe) begin
      pa_data_r <= ZERO_RST;
      pb_data_r <= ZERO_RST;
      rdata_r   <= UNMAPPED_READ;
    end else begin
      pa_data_r <= pa_data_nxt;
      pb_data_r <= pb_data_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // Pins drive only where software set the direction bit
  assign rdata  = rdata_r;
  assign pa_out = pa_data_r;
  assign pa_oe  = pa_dir_r;
  assign pb_out = pb_data_r;
  assign pb_oe  = pb_dir_r;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (wipe);

  property p_reset_values;
    $rose(nrst) && !stby_s2_r |-> mode_r == PATTERN_MODE_RST && ctrl_r == TRIGGER_CTRL_RST;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Bad mode/control reset");

  property p_dir_reset;
    $rose(nrst) && !stby_s2_r |-> pa_oe == ZERO_RST && pb_oe == ZERO_RST;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("Direction not cleared");

  property p_standby_clear;
    $fell(stby_s2_r) && nrst |-> nd_lo_r == ZERO_RST && nd_hi_r == ZERO_RST;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("Next data survived");

  property p_pa_locked;
    wr_pa_data && !gtrig[0] && !gtrig[1] && !mode_r[0] && !mode_r[1]
      |=> ((pa_out ^ $past(pa_out)) & $past(en_lo_r)) == ZERO_RST;
  endproperty
  a_pa_locked: assert property (p_pa_locked) else $error("CPU wrote locked port A bit");

  property p_pb_locked;
    wr_pb_data && !gtrig[2] && !mode_r[2]
      |=> ((pb_out ^ $past(pb_out)) & $past(pb_lock)) == ZERO_RST;
  endproperty
  a_pb_locked: assert property (p_pb_locked) else $error("CPU wrote locked port B bit");

  property p_copy_g0;
    gtrig[0] && !mode_r[0] |=> pa_out[3:0] ==
      (($past(pa_cpu[3:0]) & ~$past(en_lo_r[3:0])) | ($past(nd_lo_r[3:0]) & $past(en_lo_r[3:0])));
  endproperty
  a_copy_g0: assert property (p_copy_g0) else $error("Group 0 copy wrong");

  property p_lo_same_sec;
    req.rd && req.addr == NEXT_LO_SEC_ADDR && same_lo |=> rdata == RESERVED_READ;
  endproperty
  a_lo_same_sec: assert property (p_lo_same_sec) else $error("FFA7 not all ones");

  property p_lo_diff_pri;
    req.rd && req.addr == NEXT_LO_PRI_ADDR && !same_lo
      |=> rdata[3:0] == 4'hF && rdata[7:4] == $past(nd_lo_r[7:4]);
  endproperty
  a_lo_diff_pri: assert property (p_lo_diff_pri) else $error("FFA5 split read wrong");

  property p_hi_same_sec;
    req.rd && req.addr == NEXT_HI_SEC_ADDR && same_hi |=> rdata == RESERVED_READ;
  endproperty
  a_hi_same_sec: assert property (p_hi_same_sec) else $error("FFA6 not all ones");

  property p_group3_quiet;
    !wr_pb_data |=> pb_out[7:4] == $past(pb_out[7:4]);
  endproperty
  a_group3_quiet: assert property (p_group3_quiet) else $error("Group 3 moved a pin");

  property p_disabled_hold;
    !wr_pa_data ##1 1'b1 |-> ((pa_out ^ $past(pa_out)) & ~$past(en_lo_r)) == ZERO_RST;
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("Disabled bit changed");

  property p_dir_read;
    req.rd && (req.addr == PORT_A_DIR_ADDR || req.addr == PORT_B_DIR_ADDR)
      |=> rdata == WRITE_ONLY_READ;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("Direction register read back");

  property p_copy_g2;
    gtrig[2] && !mode_r[2] |=> pb_out[3:0] ==
      (($past(pb_cpu[3:0]) & ~$past(en_hi_r[3:0])) | ($past(nd_hi_r[3:0]) & $past(en_hi_r[3:0])));
  endproperty
  a_copy_g2: assert property (p_copy_g2) else $error("Group 2 copy wrong");

endmodule : timing_pattern_output

// File: rtl/pattern_output_pkg.sv
// Constants and carrier types for the timing pattern output unit
package pattern_output_pkg;

  // ********************************
  // Register addresses
  // ********************************
  localparam logic [15:0] PATTERN_MODE_ADDR   = 16'hFFA0;
  localparam logic [15:0] TRIGGER_CTRL_ADDR   = 16'hFFA1;
  localparam logic [15:0] ENABLE_HI_ADDR      = 16'hFFA2;
  localparam logic [15:0] ENABLE_LO_ADDR      = 16'hFFA3;
  localparam logic [15:0] NEXT_HI_PRI_ADDR    = 16'hFFA4;
  localparam logic [15:0] NEXT_LO_PRI_ADDR    = 16'hFFA5;
  localparam logic [15:0] NEXT_HI_SEC_ADDR    = 16'hFFA6;
  localparam logic [15:0] NEXT_LO_SEC_ADDR    = 16'hFFA7;
  localparam logic [15:0] PORT_A_DIR_ADDR     = 16'hFFD1;
  localparam logic [15:0] PORT_A_DATA_ADDR    = 16'hFFD3;
  localparam logic [15:0] PORT_B_DIR_ADDR     = 16'hFFD4;
  localparam logic [15:0] PORT_B_DATA_ADDR    = 16'hFFD6;

  // ********************************
  // Reset and read values
  // ********************************
  localparam logic [7:0]  PATTERN_MODE_RST    = 8'hF0;
  localparam logic [7:0]  TRIGGER_CTRL_RST    = 8'hFF;
  localparam logic [7:0]  ZERO_RST            = 8'h00;
  localparam logic [7:0]  RESERVED_READ       = 8'hFF;
  localparam logic [7:0]  WRITE_ONLY_READ     = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ       = 8'h00;
  localparam logic [7:0]  UPPER_NIBBLE        = 8'hF0;
  localparam logic [7:0]  LOWER_NIBBLE        = 8'h0F;

  // ********************************
  // Field layout
  // ********************************
  localparam int          GROUP_W             = 4;
  localparam int          PIN_GROUPS          = 3;
  localparam int          SEL_W               = 2;
  localparam int          TRIG_CH             = 4;

  // ********************************
  // Timing
  // ********************************
  localparam int          CLK_PERIOD_NS       = 8;
  localparam int          NOV_MARGIN_NS       = 80;
  localparam int          NOV_MARGIN_CYC      = (NOV_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  NOV_MARGIN_CNT      = 4'(NOV_MARGIN_CYC);
  localparam logic [3:0]  NOV_LAST_CNT        = 4'h1;

  // ********************************
  // Types
  // ********************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cpu_req_t;

  typedef struct packed {
    logic [GROUP_W-1:0] clr;
    logic [GROUP_W-1:0] set;
  } group_upd_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_MARGIN = 2'b10
  } nov_state_t;

endpackage : pattern_output_pkg

// File: rtl/group_stage.sv
// One four-bit output group: direct or non-overlapped update of its pins
`timescale 1ns/10ps
module group_stage
  import pattern_output_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               wipe,
  input  wire logic               trig,
  input  wire logic               nov,
  input  wire logic [GROUP_W-1:0] en,
  input  wire logic [GROUP_W-1:0] nd,
  output group_upd_t              upd
);

  nov_state_t         state_r;
  nov_state_t         state_nxt;
  logic [3:0]         cnt_r;
  logic [3:0]         cnt_nxt;
  logic [GROUP_W-1:0] pend_r;
  logic [GROUP_W-1:0] pend_nxt;
  logic               margin_done;

  // Falling bits go at once, rising bits wait out the margin
  assign margin_done = (state_r == ST_MARGIN) && (cnt_r == NOV_LAST_CNT) && !trig;
  assign upd.clr     = trig ? (en & ~nd) : '0;
  assign upd.set     = (trig && !nov) ? (en & nd) :
                       (margin_done ? pend_r : '0);
  assign pend_nxt    = (trig && nov) ? (en & nd) : pend_r;
  // A retrigger inside the margin restarts it with the new data
  // A direct trigger drops any pending margin so stale data never lands later
  assign state_nxt   = trig ? (nov ? ST_MARGIN : ST_IDLE) : (margin_done ? ST_IDLE : state_r);
  assign cnt_nxt     = (trig && nov) ? NOV_MARGIN_CNT :
                       ((state_r == ST_MARGIN) ? cnt_r - 4'h1 : cnt_r);

  always_ff @(posedge clk) begin
    if (wipe) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      pend_r  <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pend_r  <= pend_nxt;
    end
  end

  property p_nov_hold;
    @(posedge clk) disable iff (wipe)
    (trig && nov && |(en & nd)) ##1 (!trig)[*8] |-> (upd.set == '0);
  endproperty
  a_nov_hold: assert property (p_nov_hold) else $error("Rising bits left the margin early");

endmodule : group_stage

// File: tb/pin_load_model.sv
// Load on the pattern output pins: pull-ups where nothing drives
`timescale 1ns/10ps
module pin_load_model (
  input  wire logic [7:0]  pa_out,
  input  wire logic [7:0]  pa_oe,
  input  wire logic [7:0]  pb_out,
  input  wire logic [7:0]  pb_oe,
  output logic      [11:0] tp
);
  // ****
  // Pin levels
  // ****
  // Undriven pins float high, so a missing direction bit reads as 1
  // Only the low half of port B carries pattern bits
  assign tp = {(pb_out[3:0] & pb_oe[3:0]) | ~pb_oe[3:0],
               (pa_out & pa_oe) | ~pa_oe};
endmodule : pin_load_model

// File: tb/tb_top.sv
// Self-checking bench for the timing pattern output unit
`timescale 1ns/10ps
module tb_top
  import pattern_output_pkg::*;
;
  logic               clk        = 1'b0;
  logic               nrst       = 1'b0;
  logic               hw_standby = 1'b0;
  logic [TRIG_CH-1:0] cmp_match  = '0;
  cpu_req_t           req        = '0;
  logic [7:0]         rdata, pa_out, pa_oe, pb_out, pb_oe;
  logic [11:0]        tp;
  int                 n_mismatch = 0;
  int                 samples_checked = 0;

  always #4 clk = ~clk;

  timing_pattern_output dut (.clk(clk), .nrst(nrst), .hw_standby(hw_standby),
    .cmp_match(cmp_match), .req(req), .rdata(rdata), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe));
  pin_load_model load (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .pb_oe(pb_oe), .tp(tp));

  // ****
  // Bench tasks
  // ****
  task automatic check(input string what, input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    check($sformatf("reg %h", a), {4'h0, rdata}, {4'h0, exp});
    @(posedge clk);
  endtask : rd_chk

  // Leaves the bench just after the sampling edge; caller realigns
  task automatic fire(input int ch);
    cmp_match <= 4'h1 << ch;
    @(posedge clk);
    cmp_match <= '0;
    #1;
  endtask : fire

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ****
  // Scenarios
  // ****
  task automatic t_reset_values;
    rd_chk(PATTERN_MODE_ADDR, PATTERN_MODE_RST);
    rd_chk(TRIGGER_CTRL_ADDR, TRIGGER_CTRL_RST);
    rd_chk(ENABLE_LO_ADDR, 8'h00);
    rd_chk(NEXT_LO_PRI_ADDR, 8'h00);
    rd_chk(NEXT_HI_PRI_ADDR, 8'h00);
    rd_chk(NEXT_HI_SEC_ADDR, RESERVED_READ);
    rd_chk(16'hFF00, UNMAPPED_READ);
    check("pins", tp, 12'hFFF);
  endtask : t_reset_values

  task automatic t_direction;
    wr(PORT_A_DIR_ADDR, 8'hFF);
    wr(PORT_B_DIR_ADDR, 8'h0F);
    check("pa_oe", {4'h0, pa_oe}, 12'h0FF);
    check("pb_oe", {4'h0, pb_oe}, 12'h00F);
    rd_chk(PORT_A_DIR_ADDR, WRITE_ONLY_READ);
    rd_chk(PORT_B_DIR_ADDR, WRITE_ONLY_READ);
    check("pins", tp, 12'h000);
  endtask : t_direction

  task automatic t_shared_lo;
    wr(ENABLE_LO_ADDR, 8'h3C);
    wr(NEXT_LO_PRI_ADDR, 8'hA5);
    rd_chk(NEXT_LO_PRI_ADDR, 8'hA5);
    wr(NEXT_LO_SEC_ADDR, 8'h00);
    rd_chk(NEXT_LO_SEC_ADDR, RESERVED_READ);
    fire(2);
    check("pa_out", {4'h0, pa_out}, 12'h000);
    @(posedge clk);
    fire(3);
    check("pa_out", {4'h0, pa_out}, 12'h024);
    @(posedge clk);
    wr(PORT_A_DATA_ADDR, 8'hFF);
    check("pa_out", {4'h0, pa_out}, 12'h0E7);
    rd_chk(PORT_A_DATA_ADDR, 8'hE7);
    check("pins", tp, 12'h0E7);
  endtask : t_shared_lo

  task automatic t_split_lo;
    wr(TRIGGER_CTRL_ADDR, 8'hE4);
    rd_chk(TRIGGER_CTRL_ADDR, 8'hE4);
    wr(ENABLE_LO_ADDR, 8'hFF);
    wr(NEXT_LO_SEC_ADDR, 8'h0A);
    wr(NEXT_LO_PRI_ADDR, 8'h50);
    rd_chk(NEXT_LO_SEC_ADDR, 8'hFA);
    rd_chk(NEXT_LO_PRI_ADDR, 8'h5F);
    fire(0);
    check("pa_out", {4'h0, pa_out}, 12'h0EA);
    @(posedge clk);
    fire(1);
    check("pa_out", {4'h0, pa_out}, 12'h05A);
    @(posedge clk);
  endtask : t_split_lo

  task automatic t_group2;
    logic [1:0] c;
    logic [7:0] exp_pb;
    exp_pb = 8'h00;
    wr(ENABLE_HI_ADDR, 8'h0F);
    for (int ch = 0; ch < 4; ch++) begin
      c = ch[1:0];
      wr(TRIGGER_CTRL_ADDR, {c, c, 4'h4});
      wr(NEXT_HI_PRI_ADDR, {4'h9, 2'b10, c});
      rd_chk(NEXT_HI_PRI_ADDR, {4'h9, 2'b10, c});
      fire(int'(c + 2'd1));
      check("pb_out", {4'h0, pb_out}, {4'h0, exp_pb});
      @(posedge clk);
      exp_pb = {4'h0, 2'b10, c};
      fire(ch);
      check("pb_out", {4'h0, pb_out}, {4'h0, exp_pb});
      check("pins_hi", {8'h00, tp[11:8]}, {8'h00, exp_pb[3:0]});
      @(posedge clk);
    end
    wr(PORT_B_DATA_ADDR, 8'hF0);
    check("pb_out", {4'h0, pb_out}, 12'h0FB);
    rd_chk(PORT_B_DATA_ADDR, 8'hFB);
    rd_chk(ENABLE_HI_ADDR, 8'h0F);
    wr(TRIGGER_CTRL_ADDR, 8'hC4);
    wr(NEXT_HI_SEC_ADDR, 8'h0C);
    rd_chk(NEXT_HI_SEC_ADDR, 8'hFC);
    fire(0);
    check("pb_out", {4'h0, pb_out}, 12'h0FC);
    @(posedge clk);
  endtask : t_group2

  task automatic t_nonoverlap;
    wr(TRIGGER_CTRL_ADDR, 8'hE4);
    wr(NEXT_LO_SEC_ADDR, 8'h0A);
    fire(0);
    @(posedge clk);
    wr(PATTERN_MODE_ADDR, 8'hF1);
    rd_chk(PATTERN_MODE_ADDR, 8'hF1);
    wr(NEXT_LO_SEC_ADDR, 8'h05);
    fire(0);
    check("pa_low", {8'h00, pa_out[3:0]}, 12'h000);
    repeat (9) @(posedge clk);
    #1;
    check("pa_low", {8'h00, pa_out[3:0]}, 12'h000);
    @(posedge clk);
    #1;
    check("pa_low", {8'h00, pa_out[3:0]}, 12'h005);
    @(posedge clk);
    // A direct trigger inside a margin must cancel the pending rise
    wr(NEXT_LO_SEC_ADDR, 8'h0A);
    fire(0);
    check("pa_low", {8'h00, pa_out[3:0]}, 12'h000);
    wr(PATTERN_MODE_ADDR, 8'hF0);
    wr(NEXT_LO_SEC_ADDR, 8'h05);
    fire(0);
    check("pa_low", {8'h00, pa_out[3:0]}, 12'h005);
    repeat (12) @(posedge clk);
    #1;
    check("pa_low", {8'h00, pa_out[3:0]}, 12'h005);
    @(posedge clk);
  endtask : t_nonoverlap

  task automatic t_resets;
    wr(NEXT_LO_PRI_ADDR, 8'h77);
    hw_standby <= 1'b1;
    repeat (4) @(posedge clk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(NEXT_LO_PRI_ADDR, 8'h00);
    rd_chk(TRIGGER_CTRL_ADDR, TRIGGER_CTRL_RST);
    wr(PATTERN_MODE_ADDR, 8'hF3);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(PATTERN_MODE_ADDR, PATTERN_MODE_RST);
  endtask : t_resets

  // ****
  // Run
  // ****
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_direction();
    t_shared_lo();
    t_split_lo();
    t_group2();
    t_nonoverlap();
    t_resets();
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    $display("Error watchdog expired");
    tally_and_finish();
  end
endmodule : tb_top
